/* shared/status_pkg.sv */
// Functional notes
// - Remote entered only when addressed to listen while remote enable is asserted.
// - In remote, all front-panel keys except return-to-local are ignored.
// - Own talk address sets talker; untalk, listen addressing, another device's talk address or clear drops it.
// - Own listen address sets listener; unlisten, talk addressing or clear drops it.
// - Service indicator holds until serial poll read or all causes gone.
// - Return-to-local key cancels remote and restores the normal display.
// - Local lockout makes the return-to-local key inoperative.
// - Standard event status and mask are 16-bit; events latch until cleared.
// - Standard event bit B1 is unused and reads zero.
// - Reading an empty output queue sets query error, bit B2.
// - Standard event status clears on reset, clear-status, and its read query.
// - Event summary is OR of status ANDed with mask.
// - Mask read leaves it; cleared on reset or by writing zero.
// - Operation condition B5 and B6 come from trigger and arm summaries.
// - Operation condition is read-only, live; B9 set during calculation.
// - Event bits set on filtered rising or falling condition edges.
// - Filter reads harmless; reset and preset give rise all ones, fall zero.
// - Operation events latch; operation summary is OR of events ANDed with mask.
// - Operation events clear on reset, clear-status, and their read query.
// - Operation mask read leaves it; cleared on reset, preset or writing zero.
// - Own addresses derive from primary address 0 to 30, default 16.
package status_pkg;
   localparam int REG_W = 16;
   localparam logic [4:0] ADDR_DEFAULT = 5'h10;
   localparam logic [4:0] ADDR_MAX = 5'h1e;
   localparam logic [2:0] SEL_STD_STATUS = 3'h0;
   localparam logic [2:0] SEL_STD_MASK = 3'h1;
   localparam logic [2:0] SEL_OP_COND = 3'h2;
   localparam logic [2:0] SEL_OP_RISE = 3'h3;
   localparam logic [2:0] SEL_OP_FALL = 3'h4;
   localparam logic [2:0] SEL_OP_EVENT = 3'h5;
   localparam logic [2:0] SEL_OP_MASK = 3'h6;
   localparam int STD_UNUSED_BIT = 1;
   localparam int STD_QUERY_ERR_BIT = 2;
   localparam int OP_TRIG_BIT = 5;
   localparam int OP_ARM_BIT = 6;
   localparam int OP_CALC_BIT = 9;
   localparam logic [15:0] RISE_RESET = 16'hffff;
   localparam logic [15:0] FALL_RESET = 16'h0000;
   localparam logic [15:0] STD_VALID = 16'hfffd;
   localparam logic [7:0] UNTALK_CODE = 8'h5f;
   localparam logic [7:0] UNLISTEN_CODE = 8'h3f;
   localparam logic [2:0] LISTEN_GROUP = 3'h1;
   localparam logic [2:0] TALK_GROUP = 3'h2;
endpackage

/* src/op_event_group.sv */
`timescale 1ns/1ps
module op_event_group #(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Live condition and controls.
   input wire logic [W-1:0] cond,
   input wire logic [W-1:0] rise,
   input wire logic [W-1:0] fall,
   input wire logic clearEvents,
   // Latched events.
   output logic [W-1:0] events
);
   logic [W-1:0] prevCond;
   wire logic [W-1:0] hits;

   always_ff @(posedge clk) begin
      if (srst) begin
         prevCond <= '0;
      end else begin
         prevCond <= cond;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign hits[i] = (rise[i] & cond[i] & ~prevCond[i]) |
                          (fall[i] & ~cond[i] & prevCond[i]);
      end
   endgenerate

   // A new hit outranks a clear in the same cycle, so no event is lost.
   always_ff @(posedge clk) begin
      if (srst) begin
         events <= '0;
      end else if (clearEvents) begin
         events <= hits;
      end else begin
         events <= events | hits;
      end
   end

   a_edge_sets: assert property (@(posedge clk) disable iff (srst)
      (rise[0] && cond[0] && !prevCond[0]) |=> events[0])
      else $error("rising edge did not latch event");
endmodule

/* src/status_event_reporting.sv */
`timescale 1ns/1ps
module status_event_reporting (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Bus management lines, from pins.
   input wire logic remoteEnablePin,
   input wire logic interfaceClearPin,
   input wire logic attentionPin,
   input wire logic [7:0] dataPin,
   input wire logic dataStrobe,
   input wire logic localLockout,
   input wire logic [4:0] primaryAddress,
   // Front panel.
   input wire logic localKey,
   input wire logic [7:0] panelKeys,
   output logic [7:0] panelKeysGated,
   output logic restoreDisplay,
   // Indicators.
   output logic remote_indicator,
   output logic talker_indicator,
   output logic listener_indicator,
   output logic service_indicator,
   // Service request handshake.
   input wire logic serviceRequest,
   input wire logic serviceCauses,
   input wire logic serialPollRead,
   // Status events and conditions.
   input wire logic [15:0] standardEvents,
   input wire logic query_error,
   input wire logic outputQueueEmpty,
   input wire logic outputQueueRead,
   input wire logic triggerSummary,
   input wire logic armSummary,
   input wire logic calcBusy,
   input wire logic [15:0] otherConditions,
   // Register access by command.
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [2:0] regSelect,
   input wire logic [15:0] regWriteData,
   input wire logic clear_status_command,
   input wire logic statusPreset,
   output logic [15:0] regReadData,
   // Summaries.
   output logic event_summary_bit,
   output logic operation_summary_bit
);
   localparam int W = status_pkg::REG_W;

   // Pin synchronisers: two flops each for the bus lines before use; localLockout and primaryAddress are used unsynchronised.
   logic [11:0] syncA;
   logic [11:0] syncB;
   always_ff @(posedge clk) begin
      if (srst) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= {remoteEnablePin, interfaceClearPin, attentionPin, dataStrobe, dataPin};
         syncB <= syncA;
      end
   end
   logic renS, ifcS, atnS, strobeS, strobeD;
   logic [7:0] dataS;
   assign renS = syncB[11];
   assign ifcS = syncB[10];
   assign atnS = syncB[9];
   assign strobeS = syncB[8];
   assign dataS = syncB[7:0];
   always_ff @(posedge clk) begin
      if (srst) begin
         strobeD <= 1'b0;
      end else begin
         strobeD <= strobeS;
      end
   end

   // Command byte decode, taken on a strobe edge with attention.
   logic cmdValid, myListen, myTalk, untalk, unlisten, otherTalk;
   logic [4:0] ownAddr;
   assign ownAddr = (primaryAddress > status_pkg::ADDR_MAX) ?
                    status_pkg::ADDR_DEFAULT : primaryAddress;
   assign cmdValid = strobeS & ~strobeD & atnS;
   assign myListen = cmdValid && dataS[7:5] == status_pkg::LISTEN_GROUP &&
                     dataS[4:0] == ownAddr;
   assign myTalk = cmdValid && dataS[7:5] == status_pkg::TALK_GROUP &&
                   dataS[4:0] == ownAddr;
   assign untalk = cmdValid && dataS == status_pkg::UNTALK_CODE;
   assign unlisten = cmdValid && dataS == status_pkg::UNLISTEN_CODE;
   assign otherTalk = cmdValid && dataS[7:5] == status_pkg::TALK_GROUP &&
                      dataS[4:0] != ownAddr && !untalk;

   logic localKeyHonoured;
   assign localKeyHonoured = localKey & ~localLockout;

   // Remote state.
   always_ff @(posedge clk) begin
      if (srst) begin
         remote_indicator <= 1'b0;
      end else if (!renS) begin
         remote_indicator <= 1'b0;
      end else if (myListen) begin
         remote_indicator <= 1'b1;
      end else if (localKeyHonoured) begin
         remote_indicator <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         restoreDisplay <= 1'b0;
      end else begin
         restoreDisplay <= localKeyHonoured & remote_indicator;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         panelKeysGated <= 8'h00;
      end else begin
         panelKeysGated <= remote_indicator ? 8'h00 : panelKeys;
      end
   end

   // Talker and listener states.
   always_ff @(posedge clk) begin
      if (srst) begin
         talker_indicator <= 1'b0;
      end else if (ifcS || untalk || myListen || otherTalk) begin
         talker_indicator <= 1'b0;
      end else if (myTalk) begin
         talker_indicator <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         listener_indicator <= 1'b0;
      end else if (ifcS || unlisten || myTalk) begin
         listener_indicator <= 1'b0;
      end else if (myListen) begin
         listener_indicator <= 1'b1;
      end
   end

   // Service request indicator.
   always_ff @(posedge clk) begin
      if (srst) begin
         service_indicator <= 1'b0;
      end else if (serviceRequest) begin
         service_indicator <= 1'b1;
      end else if (serialPollRead || !serviceCauses) begin
         service_indicator <= 1'b0;
      end
   end

   // Register control decode.
   logic wrStdMask, wrRise, wrFall, wrOpMask, rdStd, rdOpEvent;
   assign wrStdMask = regWrite && regSelect == status_pkg::SEL_STD_MASK;
   assign wrRise = regWrite && regSelect == status_pkg::SEL_OP_RISE;
   assign wrFall = regWrite && regSelect == status_pkg::SEL_OP_FALL;
   assign wrOpMask = regWrite && regSelect == status_pkg::SEL_OP_MASK;
   assign rdStd = regRead && regSelect == status_pkg::SEL_STD_STATUS;
   assign rdOpEvent = regRead && regSelect == status_pkg::SEL_OP_EVENT;

   // Standard event status.
   logic [15:0] stdStatus, stdMask, stdSet;
   always_comb begin
      stdSet = standardEvents;
      stdSet[status_pkg::STD_QUERY_ERR_BIT] = standardEvents[status_pkg::STD_QUERY_ERR_BIT] |
         query_error | (outputQueueRead & outputQueueEmpty);
      stdSet = stdSet & status_pkg::STD_VALID;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stdStatus <= '0;
      end else if (rdStd || clear_status_command) begin
         stdStatus <= stdSet;
      end else begin
         stdStatus <= stdStatus | stdSet;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stdMask <= '0;
      end else if (wrStdMask) begin
         stdMask <= regWriteData;
      end
   end

   // Operation condition, filters, events and mask.
   logic [15:0] opCond, opRise, opFall, opEvents, opMask;
   always_comb begin
      opCond = otherConditions;
      opCond[status_pkg::OP_TRIG_BIT] = triggerSummary;
      opCond[status_pkg::OP_ARM_BIT] = armSummary;
      opCond[status_pkg::OP_CALC_BIT] = calcBusy;
   end

   always_ff @(posedge clk) begin
      if (srst || statusPreset) begin
         opRise <= status_pkg::RISE_RESET;
         opFall <= status_pkg::FALL_RESET;
      end else begin
         if (wrRise) begin
            opRise <= regWriteData;
         end
         if (wrFall) begin
            opFall <= regWriteData;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || statusPreset) begin
         opMask <= '0;
      end else if (wrOpMask) begin
         opMask <= regWriteData;
      end
   end

   op_event_group #(.W(W)) u_events (
      .clk(clk),
      .srst(srst),
      .cond(opCond),
      .rise(opRise),
      .fall(opFall),
      .clearEvents(rdOpEvent | clear_status_command),
      .events(opEvents)
   );

   // Summaries, registered from current contents.
   always_ff @(posedge clk) begin
      if (srst) begin
         event_summary_bit <= 1'b0;
         operation_summary_bit <= 1'b0;
      end else begin
         event_summary_bit <= |(stdStatus & stdMask);
         operation_summary_bit <= |(opEvents & opMask);
      end
   end

   // Read port; reads have no effect on filters or masks.
   always_ff @(posedge clk) begin
      if (srst) begin
         regReadData <= '0;
      end else if (regRead) begin
         case (regSelect)
            status_pkg::SEL_STD_STATUS: regReadData <= stdStatus;
            status_pkg::SEL_STD_MASK: regReadData <= stdMask;
            status_pkg::SEL_OP_COND: regReadData <= opCond;
            status_pkg::SEL_OP_RISE: regReadData <= opRise;
            status_pkg::SEL_OP_FALL: regReadData <= opFall;
            status_pkg::SEL_OP_EVENT: regReadData <= opEvents;
            status_pkg::SEL_OP_MASK: regReadData <= opMask;
            default: regReadData <= '0;
         endcase
      end
   end

   a_remote_needs_ren: assert property (@(posedge clk) disable iff (srst)
      $rose(remote_indicator) |-> $past(renS))
      else $error("remote entered without remote enable");
   a_lockout_holds: assert property (@(posedge clk) disable iff (srst)
      (remote_indicator && renS && localLockout && !srst) |=> remote_indicator)
      else $error("remote left under lockout");
   a_keys_blocked: assert property (@(posedge clk) disable iff (srst)
      remote_indicator |=> panelKeysGated == 8'h00)
      else $error("keys passed in remote");
   a_std_b1_zero: assert property (@(posedge clk) disable iff (srst)
      stdStatus[status_pkg::STD_UNUSED_BIT] == 1'b0)
      else $error("unused standard bit set");
   a_query_error: assert property (@(posedge clk) disable iff (srst)
      (outputQueueRead && outputQueueEmpty) |=> stdStatus[status_pkg::STD_QUERY_ERR_BIT])
      else $error("query error not latched");
   a_std_clear: assert property (@(posedge clk) disable iff (srst)
      (clear_status_command && standardEvents == 16'h0000 && !query_error && !outputQueueRead)
      |=> stdStatus == 16'h0000)
      else $error("standard status not cleared");
   a_esb_track: assert property (@(posedge clk) disable iff (srst)
      ##1 event_summary_bit == |($past(stdStatus) & $past(stdMask)))
      else $error("event summary wrong");
   a_preset_filters: assert property (@(posedge clk) disable iff (srst)
      statusPreset |=> opRise == 16'hffff && opFall == 16'h0000 && opMask == 16'h0000)
      else $error("preset values wrong");
   a_talk_drop: assert property (@(posedge clk) disable iff (srst)
      (ifcS || untalk) |=> !talker_indicator)
      else $error("talker not dropped");
   a_listen_drop: assert property (@(posedge clk) disable iff (srst)
      (ifcS || unlisten) |=> !listener_indicator)
      else $error("listener not dropped");
   a_local_cancel: assert property (@(posedge clk) disable iff (srst)
      (remote_indicator && localKeyHonoured && renS && !myListen) |=> !remote_indicator)
      else $error("local key did not cancel remote");
   a_restore_pulse: assert property (@(posedge clk) disable iff (srst)
      (remote_indicator && localKeyHonoured) |=> restoreDisplay)
      else $error("display not restored");
   a_service_hold: assert property (@(posedge clk) disable iff (srst)
      (service_indicator && !serialPollRead && serviceCauses) |=> service_indicator)
      else $error("service indicator dropped early");
   a_service_drop: assert property (@(posedge clk) disable iff (srst)
      (!serviceRequest && (serialPollRead || !serviceCauses)) |=> !service_indicator)
      else $error("service indicator not dropped");
   a_talk_set: assert property (@(posedge clk) disable iff (srst)
      (myTalk && !ifcS) |=> talker_indicator)
      else $error("talker not entered");
   a_listen_set: assert property (@(posedge clk) disable iff (srst)
      (myListen && !ifcS) |=> listener_indicator)
      else $error("listener not entered");
   a_talk_on_listen: assert property (@(posedge clk) disable iff (srst)
      myListen |=> !talker_indicator)
      else $error("talker kept when addressed to listen");
   a_listen_on_talk: assert property (@(posedge clk) disable iff (srst)
      myTalk |=> !listener_indicator)
      else $error("listener kept when addressed to talk");
   a_std_latch: assert property (@(posedge clk) disable iff (srst)
      (!rdStd && !clear_status_command) |=> (stdStatus & $past(stdStatus)) == $past(stdStatus))
      else $error("standard event bit lost");
   a_std_read_keep: assert property (@(posedge clk) disable iff (srst)
      (rdStd && query_error) |=> stdStatus[status_pkg::STD_QUERY_ERR_BIT])
      else $error("event lost on read clear");
   a_mask_stable: assert property (@(posedge clk) disable iff (srst)
      !wrStdMask |=> $stable(stdMask))
      else $error("standard mask changed without write");
   a_mask_write: assert property (@(posedge clk) disable iff (srst)
      wrStdMask |=> stdMask == $past(regWriteData))
      else $error("standard mask write not taken");
   a_op_mask_stable: assert property (@(posedge clk) disable iff (srst)
      (!wrOpMask && !statusPreset) |=> $stable(opMask))
      else $error("operation mask changed without write");
   a_filter_stable: assert property (@(posedge clk) disable iff (srst)
      (!wrRise && !statusPreset) |=> $stable(opRise))
      else $error("rise filter changed without write");
   a_osb_track: assert property (@(posedge clk) disable iff (srst)
      ##1 operation_summary_bit == |($past(opEvents) & $past(opMask)))
      else $error("operation summary wrong");
   c_remote: cover property (@(posedge clk) $rose(remote_indicator));
   c_service: cover property (@(posedge clk) $fell(service_indicator));
   c_local_key: cover property (@(posedge clk) restoreDisplay);
   c_osb: cover property (@(posedge clk) operation_summary_bit);
   c_esb: cover property (@(posedge clk) event_summary_bit);
endmodule

/* test/bus_controller_model.sv */
`timescale 1ns/1ps
module bus_controller_model (
   // Clock.
   input wire logic clk,
   // Bus management lines.
   output logic remoteEnablePin,
   output logic interfaceClearPin,
   output logic attentionPin,
   output logic [7:0] dataPin,
   output logic dataStrobe
);
   initial begin
      remoteEnablePin = 1'b0;
      interfaceClearPin = 1'b0;
      attentionPin = 1'b0;
      dataPin = 8'h00;
      dataStrobe = 1'b0;
   end
   task automatic setRemote(input logic v);
      @(negedge clk);
      remoteEnablePin = v;
      repeat (3) @(negedge clk);
   endtask
   // Commands go out as given; the address in them need not be the one the device holds.
   task automatic send(input logic [7:0] cmd);
      @(negedge clk);
      attentionPin = 1'b1;
      dataPin = cmd;
      dataStrobe = 1'b1;
      repeat (4) @(negedge clk);
      dataStrobe = 1'b0;
      attentionPin = 1'b0;
      // Released data lines show the inverse so no stale command lingers.
      dataPin = ~cmd;
      repeat (3) @(negedge clk);
   endtask
   task automatic clearBus();
      @(negedge clk);
      interfaceClearPin = 1'b1;
      repeat (4) @(negedge clk);
      interfaceClearPin = 1'b0;
      repeat (3) @(negedge clk);
   endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk, srst, localLockout, localKey, serviceRequest, serviceCauses, serialPollRead;
   logic query_error, outputQueueEmpty, outputQueueRead, triggerSummary, armSummary, calcBusy;
   logic regWrite, regRead, clear_status_command, statusPreset;
   logic [4:0] primaryAddress;
   logic [7:0] panelKeys, panelKeysGated;
   logic [15:0] standardEvents, otherConditions, regWriteData, regReadData, v;
   logic [2:0] regSelect;
   logic restoreDisplay, remote_indicator, talker_indicator, listener_indicator;
   logic service_indicator, event_summary_bit, operation_summary_bit, seen;
   wire remoteEnablePin, interfaceClearPin, attentionPin, dataStrobe;
   wire [7:0] dataPin;
   int n_errors = 0;
   int n_compared = 0;
   localparam logic [15:0] RST_VALS [8] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'h0, 16'h0, 16'h0,
      16'h0};
   bus_controller_model bus_controller_model_inst (.clk(clk), .remoteEnablePin(remoteEnablePin),
      .interfaceClearPin(interfaceClearPin), .attentionPin(attentionPin), .dataPin(dataPin),
      .dataStrobe(dataStrobe));
   status_event_reporting status_event_reporting_inst (.clk(clk), .srst(srst),
      .remoteEnablePin(remoteEnablePin), .interfaceClearPin(interfaceClearPin),
      .attentionPin(attentionPin), .dataPin(dataPin), .dataStrobe(dataStrobe),
      .localLockout(localLockout), .primaryAddress(primaryAddress), .localKey(localKey),
      .panelKeys(panelKeys), .panelKeysGated(panelKeysGated), .restoreDisplay(restoreDisplay),
      .remote_indicator(remote_indicator), .talker_indicator(talker_indicator),
      .listener_indicator(listener_indicator), .service_indicator(service_indicator),
      .serviceRequest(serviceRequest), .serviceCauses(serviceCauses),
      .serialPollRead(serialPollRead), .standardEvents(standardEvents),
      .query_error(query_error), .outputQueueEmpty(outputQueueEmpty),
      .outputQueueRead(outputQueueRead), .triggerSummary(triggerSummary),
      .armSummary(armSummary), .calcBusy(calcBusy), .otherConditions(otherConditions),
      .regWrite(regWrite), .regRead(regRead), .regSelect(regSelect),
      .regWriteData(regWriteData), .clear_status_command(clear_status_command),
      .statusPreset(statusPreset), .regReadData(regReadData),
      .event_summary_bit(event_summary_bit), .operation_summary_bit(operation_summary_bit));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [2:0] sel, input logic [15:0] d);
      regSelect = sel;
      regWriteData = d;
      regWrite = 1'b1;
      cyc(1);
      regWrite = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [2:0] sel, output logic [15:0] d);
      regSelect = sel;
      regRead = 1'b1;
      cyc(1);
      regRead = 1'b0;
      d = regReadData;
      cyc(1);
   endtask
   task automatic t_reset_values();
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0], v);
         chk(v, RST_VALS[i]);
      end
   endtask
   task automatic t_standard();
      wr(status_pkg::SEL_STD_MASK, 16'h0004);
      rd(status_pkg::SEL_STD_MASK, v);
      rd(status_pkg::SEL_STD_MASK, v);
      chk(v, 16'h0004);
      standardEvents = 16'h0022;
      cyc(1);
      standardEvents = 16'h0;
      cyc(3);
      chk(event_summary_bit, 1'b0);
      rd(status_pkg::SEL_STD_STATUS, v);
      chk(v, 16'h0020);
      rd(status_pkg::SEL_STD_STATUS, v);
      chk(v, 16'h0);
      outputQueueRead = 1'b1;
      cyc(1);
      outputQueueRead = 1'b0;
      cyc(3);
      chk(event_summary_bit, 1'b0);
      outputQueueEmpty = 1'b1;
      outputQueueRead = 1'b1;
      cyc(1);
      outputQueueRead = 1'b0;
      cyc(3);
      chk(event_summary_bit, 1'b1);
      clear_status_command = 1'b1;
      cyc(1);
      clear_status_command = 1'b0;
      cyc(3);
      chk(event_summary_bit, 1'b0);
      query_error = 1'b1;
      regSelect = status_pkg::SEL_STD_STATUS;
      regRead = 1'b1;
      cyc(1);
      query_error = 1'b0;
      regRead = 1'b0;
      cyc(2);
      rd(status_pkg::SEL_STD_STATUS, v);
      chk(v, 16'h0004);
      wr(status_pkg::SEL_STD_MASK, 16'h0);
      rd(status_pkg::SEL_STD_MASK, v);
      chk(v, 16'h0);
   endtask
   task automatic t_operation();
      otherConditions = 16'h0001;
      calcBusy = 1'b1;
      triggerSummary = 1'b1;
      armSummary = 1'b1;
      cyc(3);
      rd(status_pkg::SEL_OP_COND, v);
      chk(v, 16'h0261);
      wr(status_pkg::SEL_OP_MASK, 16'h0200);
      cyc(2);
      chk(operation_summary_bit, 1'b1);
      rd(status_pkg::SEL_OP_EVENT, v);
      chk(v, 16'h0261);
      cyc(2);
      chk(operation_summary_bit, 1'b0);
      wr(status_pkg::SEL_OP_FALL, 16'h0200);
      wr(status_pkg::SEL_OP_RISE, 16'h0);
      calcBusy = 1'b0;
      triggerSummary = 1'b0;
      cyc(3);
      rd(status_pkg::SEL_OP_COND, v);
      chk(v, 16'h0041);
      rd(status_pkg::SEL_OP_EVENT, v);
      chk(v, 16'h0200);
      statusPreset = 1'b1;
      cyc(1);
      statusPreset = 1'b0;
      cyc(2);
      rd(status_pkg::SEL_OP_RISE, v);
      chk(v, status_pkg::RISE_RESET);
      rd(status_pkg::SEL_OP_FALL, v);
      chk(v, status_pkg::FALL_RESET);
      rd(status_pkg::SEL_OP_MASK, v);
      chk(v, 16'h0);
   endtask
   task automatic t_bus();
      bus_controller_model_inst.send(8'h30);
      chk({remote_indicator, listener_indicator}, 2'b01);
      bus_controller_model_inst.setRemote(1'b1);
      panelKeys = 8'ha5;
      cyc(2);
      chk(panelKeysGated, 8'ha5);
      bus_controller_model_inst.send(8'h50);
      chk({remote_indicator, talker_indicator}, 2'b01);
      bus_controller_model_inst.send(8'h30);
      chk({remote_indicator, talker_indicator, listener_indicator}, 3'b101);
      chk(panelKeysGated, 8'h00);
      localLockout = 1'b1;
      localKey = 1'b1;
      cyc(2);
      localKey = 1'b0;
      cyc(4);
      chk(remote_indicator, 1'b1);
      localLockout = 1'b0;
      localKey = 1'b1;
      seen = 1'b0;
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         localKey = 1'b0;
         seen = seen | restoreDisplay;
      end
      chk({seen, remote_indicator, panelKeysGated}, {2'b10, 8'ha5});
      bus_controller_model_inst.send(8'h3f);
      chk(listener_indicator, 1'b0);
      bus_controller_model_inst.send(8'h50);
      chk(talker_indicator, 1'b1);
      bus_controller_model_inst.send(8'h5f);
      chk(talker_indicator, 1'b0);
      bus_controller_model_inst.send(8'h30);
      bus_controller_model_inst.send(8'h50);
      chk({talker_indicator, listener_indicator}, 2'b10);
      bus_controller_model_inst.clearBus();
      chk(talker_indicator, 1'b0);
      bus_controller_model_inst.send(8'h30);
      bus_controller_model_inst.clearBus();
      chk(listener_indicator, 1'b0);
      primaryAddress = 5'h03;
      bus_controller_model_inst.send(8'h30);
      chk(listener_indicator, 1'b0);
      bus_controller_model_inst.send(8'h23);
      chk(listener_indicator, 1'b1);
      chk(remote_indicator, 1'b1);
      bus_controller_model_inst.setRemote(1'b0);
      chk(remote_indicator, 1'b0);
   endtask
   task automatic t_service();
      serviceCauses = 1'b1;
      serviceRequest = 1'b1;
      cyc(1);
      serviceRequest = 1'b0;
      cyc(5);
      chk(service_indicator, 1'b1);
      serialPollRead = 1'b1;
      cyc(1);
      serialPollRead = 1'b0;
      cyc(2);
      chk(service_indicator, 1'b0);
      serviceRequest = 1'b1;
      cyc(1);
      serviceRequest = 1'b0;
      cyc(2);
      chk(service_indicator, 1'b1);
      serviceCauses = 1'b0;
      cyc(3);
      chk(service_indicator, 1'b0);
   endtask
   initial begin
      {srst, localLockout, localKey, serviceRequest, serviceCauses, serialPollRead} = 6'h20;
      {query_error, outputQueueEmpty, outputQueueRead, triggerSummary, armSummary} = 5'h0;
      {calcBusy, regWrite, regRead, clear_status_command, statusPreset} = 5'h0;
      {standardEvents, otherConditions, regWriteData, panelKeys, regSelect} = '0;
      primaryAddress = 5'h1f;
      cyc(12);
      srst = 1'b0;
      cyc(3);
      t_reset_values();
      t_standard();
      t_operation();
      t_bus();
      t_service();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      test_done();
   end
endmodule
